// *** design/fpds_dev.sv ***
/*
 Write precompensation and read data separator (device end).
 Assumes the write clock and all link inputs come from another domain,
 a raw read pulse input from the drive and a policy strap pin.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpds_cfg.svh"
// Functional notes
// - write pulses shifted early, nominal or late
// - controller supplies gate, data, clock, two selects
// - gate and data held back 250 ns
// - shift stage delays zero, one, two steps
// - strap chooses always or requested precompensation
// - FM: clock every cell, data mid-cell
// - MFM: clock only between two zeros
// - separator outputs raw data and window
// - window counter from selector, ROM, register
// - sixteen counter ticks per window period
// - 32 entries: free-run and correction halves
// - read pulse re-centres window on count nine
// - ten sectors of 512 bytes per track
module fpds_dev
   import fpds_pkg::*;
#(
   parameter int SM_DIV = `FPDS_SM_DIV,
   parameter int CNT_W = 4
) (
   input wire logic clk_sys,
   input wire logic nrst,
   fpds_if.dev link,
   input wire logic rd_raw,
   input wire logic precomp_policy_strap,
   input wire logic rate_fm,
   output logic drv_wr_gate,
   output logic drv_wr_data
);
   localparam int SW = 9;
   localparam int HS = `FPDS_HOLD_STEPS;

   if (SM_DIV < 2 || SM_DIV > 127) begin : g_bad_div
      $error("fpds_dev: SM_DIV out of range");
   end
   if (2 ** CNT_W != `FPDS_WIN_CNT) begin : g_bad_cnt
      $error("fpds_dev: CNT_W must give sixteen counts");
   end
   if (HS < 2) begin : g_bad_hold
      $error("fpds_dev: hold-back shorter than two steps");
   end

   // select code to shift amount, unused code treated as nominal
   function automatic fpds_shift_e decode_sel(input logic [1:0] sel);
      case (sel)
         `FPDS_SEL_EARLY: decode_sel = SH_EARLY;
         `FPDS_SEL_LATE: decode_sel = SH_LATE;
         default: decode_sel = SH_NOM;
      endcase
   endfunction : decode_sel

   logic [SW-1:0] pin_vec;
   logic [SW-1:0] meta_r;
   logic [SW-1:0] sync_r;
   logic wclk_s;
   logic wdata_s;
   logic wgate_s;
   logic [1:0] sel_s;
   logic req_s;
   logic rd_s;
   logic strap_s;
   logic fm_s;

   // all link and pin inputs cross through two flops
   assign pin_vec = {link.wclk, link.wdata, link.wgate, link.pc_sel,
                     link.pc_req, rd_raw, precomp_policy_strap, rate_fm};

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pin_vec;
         sync_r <= meta_r;
      end
   end

   assign {wclk_s, wdata_s, wgate_s, sel_s, req_s, rd_s, strap_s, fm_s} = sync_r;

   // write side

   logic wclk_d_r;
   logic step_tick;

   // rising edge of the write clock is one 125 ns step
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wclk_d_r <= 1'b0;
      end else begin
         wclk_d_r <= wclk_s;
      end
   end

   assign step_tick = wclk_s & ~wclk_d_r;

   logic [1:0] cap_cnt_r;
   logic policy_always_r;

   // strap caught once the synchroniser has filled after reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cap_cnt_r <= 2'h0;
         policy_always_r <= `FPDS_POLICY_RST;
      end else if (cap_cnt_r != 2'h3) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
         if (cap_cnt_r == 2'h2) begin
            policy_always_r <= strap_s;
         end
      end
   end

   logic [HS-1:0] hold_d_r;
   logic [HS-1:0] hold_g_r;
   logic held_pulse;

   // gate and data lag the select lines by two steps
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hold_d_r <= '0;
         hold_g_r <= '0;
      end else if (step_tick) begin
         hold_d_r <= {hold_d_r[HS-2:0], wdata_s};
         hold_g_r <= {hold_g_r[HS-2:0], wgate_s};
      end
   end

   assign held_pulse = hold_d_r[HS-1] & hold_g_r[HS-1];

   fpds_shift_e shift_nxt;

   // selects are settled by the time the held pulse arrives
   always_comb begin
      if (policy_always_r || req_s) begin
         shift_nxt = decode_sel(sel_s);
      end else begin
         shift_nxt = SH_NOM;
      end
   end

   logic pend1_r;
   logic pend2_r;
   logic wr_out_r;
   logic gate_out_r;

   // shift stage: early leaves now, nominal after one, late after two
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pend1_r <= 1'b0;
         pend2_r <= 1'b0;
         wr_out_r <= 1'b0;
         gate_out_r <= 1'b0;
      end else if (step_tick) begin
         wr_out_r <= (held_pulse && shift_nxt == SH_EARLY) || pend1_r;
         pend1_r <= (held_pulse && shift_nxt == SH_NOM) || pend2_r;
         pend2_r <= held_pulse && shift_nxt == SH_LATE;
         gate_out_r <= hold_g_r[HS-1];
      end
   end

   assign drv_wr_data = wr_out_r;
   assign drv_wr_gate = gate_out_r;

   // read side

   logic [7:0] div_r;
   logic [7:0] div_max;
   logic sm_tick;

   // clock selector: FM reads at half the MFM counter rate
   assign div_max = fm_s ? 8'(2 * SM_DIV - 1) : 8'(SM_DIV - 1);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_r <= 8'h0;
      end else if (div_r >= div_max) begin
         div_r <= 8'h0;
      end else begin
         div_r <= div_r + 8'h1;
      end
   end

   assign sm_tick = (div_r >= div_max);

   logic rd_d_r;
   logic pend_r;
   logic rd_edge;

   // read pulse held until the next counter tick; a new edge wins
   assign rd_edge = rd_s & ~rd_d_r;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_d_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         rd_d_r <= rd_s;
         if (rd_edge) begin
            pend_r <= 1'b1;
         end else if (sm_tick) begin
            pend_r <= 1'b0;
         end
      end
   end

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   fpds_win_rom #(
      .CNT_W(CNT_W)
   ) u_rom (
      .addr({pend_r, cnt_r}),
      .next_cnt(cnt_nxt)
   );

   // state register loads the table output on each counter tick
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (sm_tick) begin
         cnt_r <= cnt_nxt;
      end
   end

   logic rwin_r;
   logic rdata_r;

   // window open for counts five to twelve, centred on nine
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rwin_r <= 1'b0;
         rdata_r <= 1'b0;
      end else begin
         rwin_r <= (cnt_r >= `FPDS_WIN_LO) && (cnt_r <= `FPDS_WIN_HI);
         rdata_r <= pend_r;
      end
   end

   assign link.rwin = rwin_r;
   assign link.rdata = rdata_r;
endmodule : fpds_dev
`default_nettype wire

// *** design/fpds_cfg.svh ***
/*
 Timing, field and table constants for the diskette precompensation and
 data separator pair.
 Assumes a 100 MHz system clock on both ends.
*/
`ifndef FPDS_CFG_SVH
`define FPDS_CFG_SVH
// system clock period
`define FPDS_CLK_NS 10
// one precompensation step, also the write clock period
`define FPDS_STEP_NS 125
// hold-back of write gate and write data
`define FPDS_HOLD_NS 250
`define FPDS_HOLD_STEPS (`FPDS_HOLD_NS / `FPDS_STEP_NS)
// write clock half period in system clocks, rounded down
`define FPDS_WCLK_HALF ((`FPDS_STEP_NS / 2) / `FPDS_CLK_NS)
// select line codes
`define FPDS_SEL_NOM 2'h0
`define FPDS_SEL_EARLY 2'h1
`define FPDS_SEL_LATE 2'h2
// window state machine
`define FPDS_ROM_DEPTH 32
`define FPDS_WIN_CNT 16
`define FPDS_CENTER 4'h9
`define FPDS_WIN_LO 4'h5
`define FPDS_WIN_HI 4'hc
`define FPDS_SM_DIV 6
// write clock periods in half a bit cell
`define FPDS_CELL_HALF 8
// track format
`define FPDS_SEC_BYTES 512
`define FPDS_TRK_SECS 10
// strap value assumed until it has been captured
`define FPDS_POLICY_RST 1'b1
`endif

// *** design/fpds_pkg.sv ***
/*
 Types shared by both ends of the precompensation / separator link.
 Assumes fpds_cfg.svh for the numeric constants.
*/
`default_nettype none
package fpds_pkg;
   // amount of delay given to one write pulse
   typedef enum logic [1:0] {
      SH_EARLY = 2'b00,
      SH_NOM = 2'b01,
      SH_LATE = 2'b10
   } fpds_shift_e;
   // controller write encoder states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CLKH = 2'b01,
      ST_DATAH = 2'b10
   } fpds_st_e;
endpackage : fpds_pkg
`default_nettype wire

// *** design/fpds_if.sv ***
/*
 Link between the diskette controller end and the precompensation /
 data separator end.
 Assumes both ends run on their own clk_sys and synchronise inputs.
*/
`timescale 1ns/100ps
`default_nettype none
interface fpds_if;
   logic wclk;
   logic wdata;
   logic wgate;
   logic [1:0] pc_sel;
   logic pc_req;
   logic rdata;
   logic rwin;
   modport dev (
      input wclk, wdata, wgate, pc_sel, pc_req,
      output rdata, rwin
   );
   modport ctl (
      output wclk, wdata, wgate, pc_sel, pc_req,
      input rdata, rwin
   );
endinterface : fpds_if
`default_nettype wire

// *** design/fpds_win_rom.sv ***
/*
 Next-state lookup table of the read window counter.
 Assumes address = {pulse seen, current count}; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpds_cfg.svh"
module fpds_win_rom
   import fpds_pkg::*;
#(
   parameter int CNT_W = 4
) (
   input wire logic [CNT_W:0] addr,
   output logic [CNT_W-1:0] next_cnt
);
   localparam int HALF = 2 ** CNT_W;

   if (2 * HALF != `FPDS_ROM_DEPTH) begin : g_bad_depth
      $error("fpds_win_rom: table depth mismatch");
   end

   logic [CNT_W-1:0] rom [0:2*HALF-1];

   // free-run half counts on, correction half lands one past centre
   for (genvar gi = 0; gi < HALF; gi++) begin : g_rom
      assign rom[gi] = CNT_W'(gi + 1);
      assign rom[gi + HALF] = CNT_W'(`FPDS_CENTER + 4'h1);
   end

   assign next_cnt = rom[addr];
endmodule : fpds_win_rom
`default_nettype wire

// *** design/fpds_ctl.sv ***
/*
 Diskette controller end: makes the write clock, encodes FM or MFM
 write pulses, drives the select lines and samples read data by window.
 Assumes the user side runs on clk_sys; link inputs are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpds_cfg.svh"
module fpds_ctl
   import fpds_pkg::*;
#(
   parameter int WCLK_HALF = `FPDS_WCLK_HALF,
   parameter int CELL_HALF = `FPDS_CELL_HALF
) (
   input wire logic clk_sys,
   input wire logic nrst,
   fpds_if.ctl link,
   input wire logic wr_en,
   input wire logic mode_mfm,
   input wire logic [1:0] pc_sel_in,
   input wire logic pc_req_in,
   input wire logic bit_valid,
   input wire logic bit_data,
   output logic bit_ready,
   output logic rd_bit_valid,
   output logic rd_bit,
   output logic [3:0] sector_idx,
   output logic [8:0] byte_idx,
   output logic track_done
);
   if (WCLK_HALF < 1 || WCLK_HALF > 255 || CELL_HALF < 1 || CELL_HALF > 16) begin : g_bad
      $error("fpds_ctl: divider or cell length out of range");
   end

   logic [7:0] div_r;
   logic wclk_r;
   logic fall;

   // write clock from the system clock; falls mark update points
   assign fall = (div_r == 8'(WCLK_HALF - 1)) & wclk_r;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_r <= 8'h0;
         wclk_r <= 1'b0;
      end else if (div_r == 8'(WCLK_HALF - 1)) begin
         div_r <= 8'h0;
         wclk_r <= ~wclk_r;
      end else begin
         div_r <= div_r + 8'h1;
      end
   end

   fpds_st_e st_r;
   logic [3:0] ph_r;
   logic last_ph;
   logic take;
   logic cur_r;
   logic wdata_r;
   logic wgate_r;
   logic [1:0] sel_r;
   logic req_r;

   assign last_ph = (ph_r == 4'(CELL_HALF - 1));
   assign bit_ready = fall & wr_en & ((st_r == ST_IDLE) | ((st_r == ST_DATAH) & last_ph));
   assign take = bit_ready & bit_valid;

   // encoder: clock half then data half of each bit cell
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_IDLE;
         ph_r <= 4'h0;
         cur_r <= 1'b0;
         wdata_r <= 1'b0;
      end else if (fall) begin
         ph_r <= last_ph ? 4'h0 : ph_r + 4'h1;
         wdata_r <= 1'b0;
         if (take) begin
            st_r <= ST_CLKH;
            ph_r <= 4'h0;
            cur_r <= bit_data;
            wdata_r <= ~mode_mfm | (~cur_r & ~bit_data);
         end else begin
            unique case (st_r)
               ST_IDLE: begin
                  ph_r <= 4'h0;
               end
               ST_CLKH: begin
                  if (last_ph) begin
                     st_r <= ST_DATAH;
                     wdata_r <= cur_r;
                  end
               end
               ST_DATAH: begin
                  if (last_ph) begin
                     st_r <= ST_IDLE;
                  end
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // selects and request held with each bit; gate follows wr_en every clock
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wgate_r <= 1'b0;
         sel_r <= `FPDS_SEL_NOM;
         req_r <= 1'b0;
      end else begin
         wgate_r <= wr_en;
         if (take) begin
            sel_r <= pc_sel_in;
            req_r <= pc_req_in;
         end
      end
   end

   assign link.wclk = wclk_r;
   assign link.wdata = wdata_r;
   assign link.wgate = wgate_r;
   assign link.pc_sel = sel_r;
   assign link.pc_req = req_r;

   logic [2:0] bit_cnt_r;
   logic [3:0] sec_r;
   logic [8:0] byte_r;
   logic done_r;

   // bytes and sectors counted over the written bit stream
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_r <= 3'h0;
         byte_r <= 9'h0;
         sec_r <= 4'h0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (take) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
               byte_r <= byte_r + 9'h1;
               if (byte_r == 9'(`FPDS_SEC_BYTES - 1)) begin
                  byte_r <= 9'h0;
                  sec_r <= sec_r + 4'h1;
                  if (sec_r == 4'(`FPDS_TRK_SECS - 1)) begin
                     sec_r <= 4'h0;
                     done_r <= 1'b1;
                  end
               end
            end
         end
      end
   end

   assign sector_idx = sec_r;
   assign byte_idx = byte_r;
   assign track_done = done_r;

   logic [1:0] rmeta_r;
   logic [1:0] rsync_r;
   logic rwin_d_r;
   logic seen_r;
   logic rbv_r;
   logic rb_r;

   // read: pulse inside an open window is a one, reported at close
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rmeta_r <= 2'h0;
         rsync_r <= 2'h0;
         rwin_d_r <= 1'b0;
         seen_r <= 1'b0;
         rbv_r <= 1'b0;
         rb_r <= 1'b0;
      end else begin
         rmeta_r <= {link.rwin, link.rdata};
         rsync_r <= rmeta_r;
         rwin_d_r <= rsync_r[1];
         rbv_r <= rwin_d_r & ~rsync_r[1];
         if (rwin_d_r && !rsync_r[1]) begin
            rb_r <= seen_r | rsync_r[0];
            seen_r <= 1'b0;
         end else if (rsync_r[1] && rsync_r[0]) begin
            seen_r <= 1'b1;
         end
      end
   end

   assign rd_bit_valid = rbv_r;
   assign rd_bit = rb_r;
endmodule : fpds_ctl
`default_nettype wire

// *** verif/fpds_checker.sv ***
/*
 link checker: timing relations on the wires between the two ends.
 assumes plain inputs taken from the link interface, one clk_sys domain.
*/
`timescale 1ns/100ps
`default_nettype none
module fpds_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic wclk,
   input wire logic wdata,
   input wire logic wgate,
   input wire logic [1:0] pc_sel,
   input wire logic pc_req,
   input wire logic rdata,
   input wire logic rwin
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // write clock levels, six system clocks each
   sequence wclk_hi_s;
      wclk [*6] ##1 !wclk;
   endsequence
   sequence wclk_lo_s;
      !wclk [*6] ##1 wclk;
   endsequence
   // one write clock period of pulse, then release
   sequence wpulse_s;
      wdata [*8] ##[1:6] !wdata;
   endsequence
   a_wclk_high_span: assert property ($rose(wclk) |-> wclk_hi_s)
      else $error("write clock high span wrong");
   a_wclk_low_span: assert property ($fell(wclk) |-> wclk_lo_s)
      else $error("write clock low span wrong");
   a_wdata_pulse_width: assert property ($rose(wdata) |-> wpulse_s)
      else $error("write pulse width wrong");
   a_wdata_in_gate: assert property (wdata |-> wgate)
      else $error("write pulse outside gate");
   a_sel_held_pulse: assert property ((wdata && $past(wdata)) |-> $stable({pc_sel, pc_req}))
      else $error("select changed under pulse");
   a_rdata_short: assert property ($rose(rdata) |-> ##[1:14] !rdata)
      else $error("read pulse too long");
   a_rdata_recentre: assert property ($rose(rdata) |-> ##[1:30] rwin)
      else $error("window not opened after pulse");
   a_rwin_min_open: assert property ($rose(rwin) |-> rwin [*6])
      else $error("window open too short");
   a_rwin_low_max: assert property ($fell(rwin) |-> ##[1:100] rwin)
      else $error("window closed too long");
endmodule : fpds_checker
`default_nettype wire

// *** verif/tb_top.sv ***
/*
 self-checking bench: controller end and separator end joined by the link.
 assumes the design files and fpds_checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpds_cfg.svh"
module tb_top;
   localparam int WP = 2 * `FPDS_WCLK_HALF; // write clock period in clocks
   localparam int TK = `FPDS_SM_DIV; // counter tick in clocks
   logic clk_sys, nrst, rd_raw, strap, rate_fm, wr_en, mode_mfm, pc_req_in;
   logic bit_valid, bit_data, bit_ready, rd_bit_valid, rd_bit, track_done;
   logic drv_wr_gate, drv_wr_data, wd_q, rw_q;
   logic [1:0] pc_sel_in;
   logic [3:0] sector_idx;
   logic [8:0] byte_idx;
   int n_errors, n_tests, n_rise, base, t, k;
   // rows: strap, request, select, expected shift (0 early, 1 nominal, 2 late)
   logic [5:0] pc_rows [8] = '{6'b1_0_00_01, 6'b1_0_01_00, 6'b1_0_10_10, 6'b1_0_11_01,
      6'b0_0_01_01, 6'b0_1_01_00, 6'b0_1_10_10, 6'b0_0_10_01};
   // rows: mfm mode, byte written
   logic [8:0] wr_rows [6] = '{9'h081, 9'h0a5, 9'h0ff, 9'h181, 9'h1a5, 9'h1ff};
   fpds_if link_if ();
   fpds_ctl fpds_ctl_inst (.clk_sys(clk_sys), .nrst(nrst), .link(link_if.ctl), .wr_en(wr_en),
      .mode_mfm(mode_mfm), .pc_sel_in(pc_sel_in), .pc_req_in(pc_req_in),
      .bit_valid(bit_valid), .bit_data(bit_data), .bit_ready(bit_ready),
      .rd_bit_valid(rd_bit_valid), .rd_bit(rd_bit), .sector_idx(sector_idx),
      .byte_idx(byte_idx), .track_done(track_done));
   fpds_dev fpds_dev_inst (.clk_sys(clk_sys), .nrst(nrst), .link(link_if.dev),
      .rd_raw(rd_raw), .precomp_policy_strap(strap), .rate_fm(rate_fm),
      .drv_wr_gate(drv_wr_gate), .drv_wr_data(drv_wr_data));
   fpds_checker fpds_checker_inst (.clk_sys(clk_sys), .nrst(nrst), .wclk(link_if.wclk),
      .wdata(link_if.wdata), .wgate(link_if.wgate), .pc_sel(link_if.pc_sel),
      .pc_req(link_if.pc_req), .rdata(link_if.rdata), .rwin(link_if.rwin));
   // system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // rising pulses on the write line, last window level
   always @(posedge clk_sys) begin
      if (link_if.wdata === 1'b1 && wd_q === 1'b0) n_rise++;
      wd_q <= link_if.wdata;
      rw_q <= link_if.rwin;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   task automatic give_verdict();
      if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic do_reset();
      nrst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
   endtask : do_reset
   // offer one bit and hold it until the controller takes it
   task automatic send_bit(input logic [1:0] sel, input logic req, input logic d);
      pc_sel_in <= sel;
      pc_req_in <= req;
      bit_data <= d;
      bit_valid <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (bit_ready !== 1'b1 && k < 400);
      if (k >= 400) check("bit taken", 16'h1, 16'h0);
   endtask : send_bit
   // clocks from a link write pulse to the drive write pulse
   task automatic measure(output int d);
      k = 0;
      while (link_if.wdata !== 1'b1 && k < 400) begin
         @(posedge clk_sys);
         k++;
      end
      d = 0;
      while (drv_wr_data !== 1'b1 && d < 200) begin
         @(posedge clk_sys);
         d++;
      end
   endtask : measure
   task automatic next_rise(output int d);
      d = 0;
      do begin
         @(posedge clk_sys);
         d++;
      end while (!(link_if.rwin === 1'b1 && rw_q === 1'b0) && d < 1000);
   endtask : next_rise
   function automatic int exp_pulses(input logic mfm, input logic [7:0] b);
      int n = 0;
      logic prev = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         if (!mfm || (!prev && !b[i])) n++;
         if (b[i]) n++;
         prev = b[i];
      end
      return n;
   endfunction : exp_pulses
   // hang guard, over two and a half times the expected run
   initial begin
      #300_000;
      n_errors++;
      give_verdict();
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      rd_raw = 1'b0;
      strap = 1'b1;
      rate_fm = 1'b0;
      wr_en = 1'b0;
      mode_mfm = 1'b0;
      pc_sel_in = 2'h0;
      pc_req_in = 1'b0;
      bit_valid = 1'b0;
      bit_data = 1'b0;
      do_reset();
      check("reset state", 16'h0, 16'({link_if.wclk, link_if.wdata, link_if.wgate,
         link_if.pc_sel, link_if.rdata, link_if.rwin, drv_wr_gate, drv_wr_data}));
      // precompensation shift: each select with strap set, early and late selects with request on and off with strap clear
      foreach (pc_rows[i]) begin
         strap <= pc_rows[i][5];
         do_reset();
         wr_en <= 1'b1;
         send_bit(pc_rows[i][3:2], pc_rows[i][4], 1'b0);
         bit_valid <= 1'b0;
         measure(t);
         if (i == 0) base = t;
         check("drive gate", 16'h1, 16'(drv_wr_gate));
         check("shift delay", 16'(base + (int'(pc_rows[i][1:0]) - 1) * WP), 16'(t));
      end
      check("hold back", 16'h1, 16'(base >= 3 * WP && base <= 5 * WP));
      // pulse count on the write line for fm and mfm bytes
      foreach (wr_rows[i]) begin
         mode_mfm <= wr_rows[i][8];
         strap <= 1'b1;
         do_reset();
         n_rise = 0;
         for (int b = 7; b >= 0; b--) send_bit(2'h0, 1'b0, wr_rows[i][b]);
         bit_valid <= 1'b0;
         repeat (16 * WP + 24) @(posedge clk_sys);
         check("write pulses", 16'(exp_pulses(wr_rows[i][8], wr_rows[i][7:0])),
            16'(n_rise));
         // eight bits after reset make exactly one byte
         check("byte count", 16'h1, 16'(byte_idx));
         check("sector count", 16'h0, 16'({sector_idx, track_done}));
      end
      // bits offered with writing disabled
      wr_en <= 1'b0;
      bit_valid <= 1'b1;
      t = 0;
      repeat (100) begin
         @(posedge clk_sys);
         if (bit_ready === 1'b1) t++;
      end
      bit_valid <= 1'b0;
      check("refused bits", 16'h0, 16'(t));
      check("gate off", 16'h0, 16'(link_if.wgate));
      // free-running window period at both rates
      for (int r = 0; r < 2; r++) begin
         rate_fm <= r[0];
         next_rise(t);
         next_rise(t);
         next_rise(t);
         check("window period", 16'(16 * TK * (r + 1)), 16'(t));
      end
      rate_fm <= 1'b0;
      next_rise(t);
      next_rise(t);
      // read pulses at several window phases
      foreach (wr_rows[i]) begin
         if (i < 3) begin
            next_rise(t);
            repeat (7 + 26 * i) @(posedge clk_sys);
            rd_raw <= 1'b1;
            repeat (2) @(posedge clk_sys);
            rd_raw <= 1'b0;
            t = 2;
            while (!(link_if.rwin === 1'b0 && rw_q === 1'b1) && t < 200) begin
               @(posedge clk_sys);
               t++;
               if (t == 5) check("read pulse", 16'h1, 16'(link_if.rdata));
            end
            check("window recentred", 16'h1, 16'(t >= 3 * TK && t <= 5 * TK + 2));
            // report three clocks after close; third pulse lands before its window
            repeat (3) @(posedge clk_sys);
            check("bit report", 16'h1, 16'(rd_bit_valid));
            check("bit value", 16'(i < 2), 16'(rd_bit));
         end
      end
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
